// ### design/rds_sequencer.sv
// reset delay sequencer: system reset hold, clock release and clock monitor start
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module rds_sequencer
  import rds_pkg::*;
#(
  parameter int unsigned START_NOREG = START_NOREG_CYCLES,
  parameter int unsigned MON_DELAY   = MON_CYCLES
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // reset requests and wake, asynchronous levels
  input  wire rds_reset_req_t    i_reset_req,
  input  wire logic              i_wake_req,
  // configuration
  input  wire logic [OSC_W-1:0]  i_osc_select_config,
  input  wire logic              i_primary_is_crystal,
  input  wire logic              i_clk_switch_en,
  input  wire logic              i_regulator_en,
  input  wire logic              i_clock_fail_monitor_en,
  // oscillator status pins
  input  wire logic              i_osc_clock,
  input  wire logic              i_clock_valid,
  // register port
  input  wire rds_bus_t          i_bus,
  output logic      [DATA_W-1:0] o_rdata,
  // system side
  output logic                   o_system_reset_out,
  output logic                   o_core_run,
  output logic      [OSC_W-1:0]  o_osc_select,
  output logic                   o_osc_fail_trap,
  output logic                   o_irq
);

  if (START_NOREG < 1 || START_NOREG >= (1 << CNT_W)) begin : g_bad_start
    $error("start-up count out of range");
  end
  if (MON_DELAY < 1 || MON_DELAY >= (1 << CNT_W)) begin : g_bad_mon
    $error("monitor count out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic needs_ost(input logic [OSC_W-1:0] src, input logic xtal);
    needs_ost = (src == OSC_SEC) || (xtal && (src == OSC_PRI || src == OSC_PRI_PLL));
  endfunction

  function automatic logic needs_pll(input logic [OSC_W-1:0] src);
    needs_pll = (src == OSC_FRC_PLL) || (src == OSC_PRI_PLL);
  endfunction

  function automatic logic [CNT_W-1:0] phase_cycles(input rds_state_t st, input logic reg_en);
    case (st)
      ST_POR:           phase_cycles = CNT_W'(POR_CYCLES);
      ST_START, ST_WAKE: phase_cycles = reg_en ? CNT_W'(START_REG_CYCLES) : CNT_W'(START_NOREG);
      ST_IRST:          phase_cycles = CNT_W'(RST_CYCLES);
      default:          phase_cycles = '0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  rds_reset_req_t   req_m;
  rds_reset_req_t   req_s;
  logic [2:0]       osc_s;
  logic [1:0]       valid_s;
  logic             boot;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      req_m   <= '0;
      req_s   <= '0;
      osc_s   <= '0;
      valid_s <= '0;
      boot    <= 1'b1;
    end else begin
      req_m   <= i_reset_req;
      req_s   <= req_m;
      osc_s   <= {osc_s[1:0], i_osc_clock};
      valid_s <= {valid_s[0], i_clock_valid};
      boot    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  rds_state_t       state;
  rds_state_t       next_state;
  logic [OSC_W-1:0] cur_osc;
  logic [OSC_W-1:0] next_cur_osc;
  logic             pow_q;
  logic             mon_armed;
  logic             clk_rel_q;
  logic [DATA_W-1:0] cause;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [CNT_W-1:0] hold_cnt;
  logic [OST_W-1:0] ost_cnt;
  logic [CNT_W-1:0] pll_cnt;
  logic [CNT_W-1:0] mon_cnt;
  logic             hold_zero;
  logic             ost_zero;
  logic             pll_zero;
  logic             mon_zero;
  logic             mon_fail;

  wire req_por   = req_s.por | boot;
  wire req_bor   = req_s.bor;
  wire req_pow   = req_por | req_bor;
  wire req_any   = req_pow | (|req_s);
  wire osc_edge  = osc_s[1] & ~osc_s[2];
  wire wr_cause  = i_bus.wr && i_bus.addr == REG_RESET_CAUSE;
  wire wr_osc    = i_bus.wr && i_bus.addr == REG_OSC_CONTROL;
  wire wr_status = i_bus.wr && i_bus.addr == REG_IRQ_STATUS;
  wire wr_mask   = i_bus.wr && i_bus.addr == REG_IRQ_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // hold sequence
  always_comb begin
    next_state = state;
    if (req_any) begin
      next_state = req_por ? ST_POR : (req_bor ? ST_START : ST_IRST);
    end else begin
      case (state)
        ST_POR:   if (hold_zero) next_state = ST_START;
        ST_START: if (hold_zero) next_state = ST_IRST;
        ST_IRST:  if (hold_zero) next_state = ST_RUN;
        ST_WAKE:  if (hold_zero) next_state = ST_RUN;
        ST_RUN:   if (i_wake_req && i_regulator_en) next_state = ST_WAKE;
        default:  next_state = ST_RUN;
      endcase
    end
  end

  wire hold_load  = req_any | (next_state != state);
  wire next_sys   = next_state == ST_POR || next_state == ST_START || next_state == ST_IRST;
  wire release_ev = o_system_reset_out & ~next_sys;

  rds_down_counter #(.W(CNT_W)) u_hold (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (hold_load),
    .i_value (phase_cycles(next_state, i_regulator_en)),
    .i_step  (1'b1),
    .o_count (hold_cnt),
    .o_zero  (hold_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock source and oscillator delays, alongside the hold
  always_comb begin
    next_cur_osc = cur_osc;
    if (req_any && (req_pow || !i_clk_switch_en)) begin
      next_cur_osc = i_osc_select_config;
    end else if (req_any) begin
      next_cur_osc = cur_osc;
    end else if (mon_fail) begin
      next_cur_osc = OSC_FRC;
    end else if (wr_osc && i_clk_switch_en) begin
      next_cur_osc = i_bus.wdata[OC_CURRENT_OSC_FIELD_LO +: OSC_W];
    end
  end

  wire need_ost = req_pow && needs_ost(next_cur_osc, i_primary_is_crystal);
  wire need_pll = req_pow && needs_pll(next_cur_osc);

  rds_down_counter #(.W(OST_W)) u_ost (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (req_any),
    .i_value (need_ost ? OST_W'(OST_PERIODS) : '0),
    .i_step  (osc_edge),
    .o_count (ost_cnt),
    .o_zero  (ost_zero)
  );

  rds_down_counter #(.W(CNT_W)) u_pll (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (req_any),
    .i_value (need_pll ? CNT_W'(LOCK_CYCLES) : '0),
    .i_step  (1'b1),
    .o_count (pll_cnt),
    .o_zero  (pll_zero)
  );

  wire clk_rel = ost_zero & pll_zero & ~req_any;

  ////////////////////////////////////////////////////////////////////////////
  // clock monitor
  wire mon_slow = pow_q && (needs_ost(cur_osc, i_primary_is_crystal) || needs_pll(cur_osc));
  wire mon_active = mon_armed & mon_zero & i_clock_fail_monitor_en;
  assign mon_fail = mon_active & ~valid_s[1] & (cur_osc != OSC_FRC) & ~req_any;

  rds_down_counter #(.W(CNT_W)) u_mon (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (release_ev),
    .i_value (mon_slow ? CNT_W'(MON_DELAY) : '0),
    .i_step  (1'b1),
    .o_count (mon_cnt),
    .o_zero  (mon_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  wire [DATA_W-1:0] cause_base = wr_cause ? (i_bus.wdata & M_CAUSE) : cause;
  wire [DATA_W-1:0] cause_clr  = req_por ? M_CAUSE : (req_bor ? (M_CAUSE & ~M_EXTR) : '0);
  wire [DATA_W-1:0] cause_set  = ({DATA_W{req_por}} & (M_POR | M_BOR))
                               | ({DATA_W{req_bor}} & M_BOR)
                               | ({DATA_W{req_s.master_clear_pin}} & M_EXTR)
                               | ({DATA_W{req_s.wdt}} & M_WDTO)
                               | ({DATA_W{req_s.sw}} & M_SWR)
                               | ({DATA_W{req_s.illop | req_s.uninit_w}} & M_ILLOP)
                               | ({DATA_W{req_s.trap_conflict}} & M_TRAP);
  wire [DATA_W-1:0] next_cause = (cause_base & ~cause_clr) | cause_set;

  wire [IRQ_W-1:0] irq_ev = {mon_fail, clk_rel & ~clk_rel_q, release_ev};
  wire [IRQ_W-1:0] irq_clr = wr_status ? i_bus.wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_ev;

  wire [DATA_W-1:0] osc_word = {1'b0, cur_osc, 10'h000, mon_active, clk_rel_q};
  wire [DATA_W-1:0] read_mux =
      (i_bus.addr == REG_RESET_CAUSE) ? cause :
      (i_bus.addr == REG_OSC_CONTROL) ? osc_word :
      (i_bus.addr == REG_IRQ_STATUS)  ? {13'h0000, irq_status} :
      (i_bus.addr == REG_IRQ_MASK)    ? {13'h0000, irq_mask} : '0;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state              <= ST_POR;
      cur_osc            <= OSC_FRC;
      pow_q              <= 1'b1;
      mon_armed          <= 1'b0;
      clk_rel_q          <= 1'b0;
      cause              <= CAUSE_RST;
      irq_status         <= IRQ_RST;
      irq_mask           <= IRQ_RST;
      o_rdata            <= '0;
      o_system_reset_out <= 1'b1;
      o_core_run         <= 1'b0;
      o_osc_fail_trap    <= 1'b0;
    end else begin
      state              <= next_state;
      cur_osc            <= next_cur_osc;
      pow_q              <= req_any ? req_pow : pow_q;
      mon_armed          <= ~req_any & (mon_armed | release_ev);
      clk_rel_q          <= clk_rel;
      cause              <= next_cause;
      irq_status         <= next_irq_status;
      irq_mask           <= wr_mask ? i_bus.wdata[IRQ_W-1:0] : irq_mask;
      o_rdata            <= i_bus.rd ? read_mux : '0;
      o_system_reset_out <= next_sys;
      o_core_run         <= (next_state == ST_RUN) & clk_rel;
      o_osc_fail_trap    <= mon_fail;
    end
  end

  assign o_osc_select = cur_osc;
  assign o_irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_req_holds_reset: assert property (req_any |=> o_system_reset_out)
    else $error("reset request did not assert system reset");

  a_por_full_hold: assert property (req_por |=> state == ST_POR && hold_cnt == POR_CYCLES)
    else $error("power-on reset did not start with power-on delay");

  a_bor_skips_por: assert property ((req_bor && !req_por) |=> state == ST_START)
    else $error("brownout reset did not skip power-on delay");

  a_other_irst_only: assert property ((req_any && !req_pow)
    |=> state == ST_IRST && hold_cnt == RST_CYCLES && ost_zero && pll_zero)
    else $error("core reset added more than internal reset time");

  a_irst_release: assert property ((state == ST_IRST && hold_zero && !req_any)
    |=> !o_system_reset_out ##1 !o_system_reset_out || $past(req_any))
    else $error("system reset not released after internal reset time");

  a_wake_startup: assert property ((state == ST_RUN && !req_any && i_wake_req
    && i_regulator_en) |=> state == ST_WAKE && hold_cnt == START_REG_CYCLES && !o_core_run)
    else $error("wake did not apply start-up delay");

  a_pll_parallel: assert property ((req_any && need_pll)
    |=> pll_cnt == LOCK_CYCLES && o_system_reset_out)
    else $error("lock delay not started with reset hold");

  a_core_gated: assert property (o_core_run |-> $past(clk_rel) && !o_system_reset_out)
    else $error("core running without released clock");

  a_power_source: assert property ((req_any && (req_pow || !i_clk_switch_en))
    |=> cur_osc == $past(i_osc_select_config))
    else $error("post-reset source not taken from config field");

  a_keep_source: assert property ((req_any && !req_pow && i_clk_switch_en)
    |=> $stable(cur_osc))
    else $error("core reset changed the current source");

  a_fail_to_rc: assert property (mon_fail
    |=> cur_osc == OSC_FRC && o_osc_fail_trap && irq_status[IRQ_FAIL])
    else $error("clock failure did not fall back to internal rc");

  a_mon_waits: assert property ((release_ev && mon_slow) |=> !mon_active)
    else $error("monitor started without its delay");

  a_flag_write_safe: assert property ((wr_cause && !req_any && !o_system_reset_out)
    |=> !o_system_reset_out && cause == ($past(i_bus.wdata) & M_CAUSE))
    else $error("cause flag write misbehaved");

  a_cause_on_por: assert property (req_por |=> cause == (M_POR | M_BOR))
    else $error("power-on reset cause value wrong");

endmodule

// ### design/rds_pkg.sv
// shared constants and types of the reset delay sequencer
package rds_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timebase and delays
  localparam int CLOCK_MHZ        = 125;
  localparam int T_POR_US         = 10;
  localparam int T_START_REG_US   = 20;
  localparam int T_START_NOREG_MS = 64;
  localparam int T_RST_US         = 20;
  localparam int T_LOCK_US        = 20;
  localparam int T_MON_US         = 100;
  // longer monitor delay figure, selectable through the top parameter
  localparam int T_MON_ALT_US     = 500;
  localparam int OST_PERIODS      = 1024;

  localparam int POR_CYCLES         = T_POR_US * CLOCK_MHZ;
  localparam int START_REG_CYCLES   = T_START_REG_US * CLOCK_MHZ;
  localparam int START_NOREG_CYCLES = T_START_NOREG_MS * 1000 * CLOCK_MHZ;
  localparam int RST_CYCLES         = T_RST_US * CLOCK_MHZ;
  localparam int LOCK_CYCLES        = T_LOCK_US * CLOCK_MHZ;
  localparam int MON_CYCLES         = T_MON_US * CLOCK_MHZ;
  localparam int MON_ALT_CYCLES     = T_MON_ALT_US * CLOCK_MHZ;

  localparam int CNT_W = 23;
  localparam int OST_W = 11;
  localparam int OSC_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int IRQ_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator source codes
  localparam logic [OSC_W-1:0] OSC_FRC     = 3'h0;
  localparam logic [OSC_W-1:0] OSC_FRC_PLL = 3'h1;
  localparam logic [OSC_W-1:0] OSC_PRI     = 3'h2;
  localparam logic [OSC_W-1:0] OSC_PRI_PLL = 3'h3;
  localparam logic [OSC_W-1:0] OSC_SEC     = 3'h4;
  localparam logic [OSC_W-1:0] OSC_LPRC    = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // register map and fields
  localparam logic [ADDR_W-1:0] REG_RESET_CAUSE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OSC_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK    = 8'h0C;

  localparam logic [DATA_W-1:0] M_TRAP  = 16'h8000;
  localparam logic [DATA_W-1:0] M_ILLOP = 16'h4000;
  localparam logic [DATA_W-1:0] M_EXTR  = 16'h0080;
  localparam logic [DATA_W-1:0] M_SWR   = 16'h0040;
  localparam logic [DATA_W-1:0] M_WDTO  = 16'h0010;
  localparam logic [DATA_W-1:0] M_BOR   = 16'h0002;
  localparam logic [DATA_W-1:0] M_POR   = 16'h0001;
  localparam logic [DATA_W-1:0] M_CAUSE = 16'hC0D3;
  localparam logic [DATA_W-1:0] CAUSE_RST = 16'h0003;

  localparam int OC_CURRENT_OSC_FIELD_LO = 12;
  localparam int OC_CLK_OK  = 0;
  localparam int OC_MON     = 1;

  localparam int IRQ_REL  = 0;
  localparam int IRQ_CLK  = 1;
  localparam int IRQ_FAIL = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic por;
    logic bor;
    logic master_clear_pin;
    logic wdt;
    logic sw;
    logic illop;
    logic uninit_w;
    logic trap_conflict;
  } rds_reset_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rds_bus_t;

  typedef enum logic [2:0] {ST_RUN, ST_POR, ST_START, ST_IRST, ST_WAKE} rds_state_t;

endpackage

// ### design/rds_down_counter.sv
// loadable down-counter used for every sequencer delay
`timescale 1ns/1ps
module rds_down_counter #(
  parameter int W = 23
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  // control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  input  wire logic         i_step,
  // state
  output logic      [W-1:0] o_count,
  output logic              o_zero
);

  if (W < 2) begin : g_bad_width
    $error("counter width too small");
  end

  assign o_zero = (o_count == '0);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_count <= '0;
    end else if (i_load) begin
      o_count <= i_value;
    end else if (i_step && !o_zero) begin
      o_count <= o_count - W'(1);
    end
  end

  a_load_restart: assert property (@(posedge i_clock) disable iff (i_rst)
    i_load |=> o_count == $past(i_value))
    else $error("counter did not restart on load");

endmodule

// ### test/rds_osc_model.sv
// oscillator pin model for the sequencer bench
`timescale 1ns/1ps
module rds_osc_model #(
  parameter int HALF_NS = 24
) (
  // control
  input  wire logic i_run,
  // pin
  output logic      o_osc_clock
);
  // no edges while stopped, like a dead crystal
  initial begin
    o_osc_clock = 1'b0;
    forever begin
      #HALF_NS;
      o_osc_clock = i_run ? ~o_osc_clock : 1'b0;
    end
  end
endmodule

// ### test/tb_rds_sequencer.sv
// self-checking bench of the reset delay sequencer
`timescale 1ns/1ps
module tb_rds_sequencer
  import rds_pkg::*;
;
  localparam int NOREG = 300;
  localparam int MOND  = 50;
  localparam int P_POR = POR_CYCLES + 1;
  localparam int P_ST  = START_REG_CYCLES + 1;
  localparam int P_RST = RST_CYCLES + 1;
  localparam int P_OSC = 1024 * 6;

  logic clock, rst, wake, xtal, sw_en, reg_en, mon_en, osc_run, osc, valid;
  logic system_reset_out, run, trap, irq;
  rds_reset_req_t    req;
  rds_bus_t          bus;
  logic [OSC_W-1:0]  cfg;
  logic [OSC_W-1:0]  sel;
  logic [DATA_W-1:0] rdata;
  int                n_errors;
  int                samples_checked;
  int                n;
  int                m;
  logic [15:0]       cb [0:5] = '{M_TRAP, M_ILLOP, M_ILLOP, M_SWR, M_WDTO, M_EXTR};

  rds_sequencer #(.START_NOREG(NOREG), .MON_DELAY(MOND)) u_rds_sequencer (
    .i_clock(clock), .i_rst(rst), .i_reset_req(req), .i_wake_req(wake),
    .i_osc_select_config(cfg), .i_primary_is_crystal(xtal), .i_clk_switch_en(sw_en),
    .i_regulator_en(reg_en), .i_clock_fail_monitor_en(mon_en), .i_osc_clock(osc),
    .i_clock_valid(valid), .i_bus(bus), .o_rdata(rdata), .o_system_reset_out(system_reset_out),
    .o_core_run(run), .o_osc_select(sel), .o_osc_fail_trap(trap), .o_irq(irq)
  );
  rds_osc_model #(.HALF_NS(24)) u_rds_osc_model (.i_run(osc_run), .o_osc_clock(osc));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks and verdict
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // bus and reset drivers
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
    #1;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] mk, e, input string nm);
    @(posedge clock);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    chk(nm, e, rdata & mk);
  endtask

  function automatic logic seen(input int w);
    case (w)
      0: return system_reset_out === 1'b0;
      1: return run === 1'b1;
      default: return trap === 1'b1;
    endcase
  endfunction

  // cycles until release, core run or trap; bounded
  task automatic wait_for(input int w, output int c);
    c = 0;
    do begin
      @(posedge clock);
      #1;
      c++;
    end while (!seen(w) && c < 20000);
    if (c >= 20000) begin
      n_errors++;
      stop_test();
    end
  endtask

  task automatic hit(input int b, output int c);
    @(posedge clock);
    req <= rds_reset_req_t'(8'(1 << b));
    repeat (3) @(posedge clock);
    req <= '0;
    wait_for(0, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_boot;
    @(posedge clock);
    rst <= 1'b0;
    wait_for(0, n);
    chk_rng("boot hold", P_POR + P_ST + P_RST - 2, P_POR + P_ST + P_RST + 8, n);
    chk("boot run", 16'h0001, 16'(run));
    chk("boot source", 16'(OSC_FRC), 16'(sel));
    rdc(REG_RESET_CAUSE, 16'hFFFF, CAUSE_RST, "boot cause");
  endtask

  task automatic t_types;
    wr(REG_OSC_CONTROL, 16'h5000);
    rdc(REG_OSC_CONTROL, 16'h7000, 16'h5000, "source field");
    for (int b = 5; b >= 0; b--) begin
      wr(REG_RESET_CAUSE, 16'h0000);
      hit(b, n);
      chk_rng("internal hold", P_RST - 2, P_RST + 8, n);
      chk("kept source", 16'(OSC_LPRC), 16'(sel));
      rdc(REG_RESET_CAUSE, 16'hFFFF, cb[b], "cause flag");
    end
  endtask

  task automatic t_bor;
    reg_en <= 1'b0;
    wr(REG_RESET_CAUSE, 16'h0090);
    @(posedge clock);
    req.master_clear_pin <= 1'b1;
    repeat (3) @(posedge clock);
    req.master_clear_pin <= 1'b0;
    // brownout arrives mid-sequence
    repeat (1000) @(posedge clock);
    hit(6, n);
    chk_rng("brownout hold", NOREG + P_RST - 1, NOREG + P_RST + 9, n);
    chk("power source", 16'(OSC_FRC), 16'(sel));
    rdc(REG_RESET_CAUSE, 16'hFFFF, 16'h0082, "brownout cause");
    reg_en <= 1'b1;
  endtask

  task automatic t_noswitch;
    wr(REG_OSC_CONTROL, 16'h5000);
    sw_en <= 1'b0;
    hit(5, n);
    chk("config source", 16'(OSC_FRC), 16'(sel));
    wr(REG_OSC_CONTROL, 16'h4000);
    rdc(REG_OSC_CONTROL, 16'h7000, 16'h0000, "locked field");
    sw_en <= 1'b1;
  endtask

  task automatic t_regs;
    wr(REG_RESET_CAUSE, 16'h0040);
    rdc(REG_RESET_CAUSE, 16'hFFFF, 16'h0040, "flag by write");
    chk("no reset", 16'h0000, 16'(system_reset_out));
    wr(REG_RESET_CAUSE, 16'hFFFF);
    rdc(REG_RESET_CAUSE, 16'hFFFF, M_CAUSE, "flag mask");
    rdc(8'h10, 16'hFFFF, 16'h0000, "unmapped read");
  endtask

  task automatic t_irq;
    wr(REG_IRQ_STATUS, 16'h0007);
    rdc(REG_IRQ_STATUS, 16'hFFFF, 16'h0000, "status clear");
    hit(5, n);
    rdc(REG_IRQ_STATUS, 16'h0001, 16'h0001, "release event");
    chk("irq masked", 16'h0000, 16'(irq));
    wr(REG_IRQ_MASK, 16'h0001);
    chk("irq raised", 16'h0001, 16'(irq));
    wr(REG_IRQ_STATUS, 16'h0007);
    chk("irq cleared", 16'h0000, 16'(irq));
  endtask

  task automatic t_xtal;
    cfg <= OSC_PRI;
    xtal <= 1'b1;
    osc_run <= 1'b1;
    hit(6, n);
    chk_rng("hold beside settle", P_ST + P_RST - 2, P_ST + P_RST + 8, n);
    chk("core held", 16'h0000, 16'(run));
    wait_for(1, m);
    chk_rng("settle count", P_OSC - 4, P_OSC + 10, n + m);
  endtask

  task automatic t_mon;
    cfg <= OSC_PRI_PLL;
    mon_en <= 1'b1;
    valid <= 1'b0;
    hit(7, n);
    chk_rng("por hold", P_POR + P_ST + P_RST - 2, P_POR + P_ST + P_RST + 8, n);
    chk("lock beside hold", 16'h0001, 16'(run));
    wait_for(2, m);
    chk_rng("monitor delay", MOND - 2, MOND + 8, m);
    chk("fallback source", 16'(OSC_FRC), 16'(sel));
    wr(REG_IRQ_MASK, 16'h0004);
    chk("fail irq", 16'h0001, 16'(irq));
    wr(REG_IRQ_STATUS, 16'h0004);
    chk("fail cleared", 16'h0000, 16'(irq));
    valid <= 1'b1;
    mon_en <= 1'b0;
  endtask

  task automatic t_wake;
    @(posedge clock);
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("wake stall", 16'h0000, 16'(run));
    wait_for(1, n);
    chk_rng("wake hold", P_ST - 2, P_ST + 8, n + 2);
    chk("wake no reset", 16'h0000, 16'(system_reset_out));
    reg_en <= 1'b0;
    @(posedge clock);
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("wake ignored", 16'h0001, 16'(run));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    wake = 1'b0;
    cfg = OSC_FRC;
    xtal = 1'b0;
    sw_en = 1'b1;
    reg_en = 1'b1;
    mon_en = 1'b0;
    osc_run = 1'b0;
    valid = 1'b1;
    bus = '0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    t_boot();
    t_types();
    t_bor();
    t_noswitch();
    t_regs();
    t_irq();
    t_xtal();
    t_mon();
    t_wake();
    stop_test();
  end
endmodule
